/* File: inc/ems_pkg.sv */
// Constants and types for the error message interrupt and stream table register bank.
// Assumes a 12-bit byte address space with one 32-bit word per register.
package ems_pkg;
    localparam int PA_W = 56;
    localparam int GERR_W = 11;
    localparam int ATTR_W = 6;
    localparam logic [11:0] OFS_CTRL0 = 12'h020;
    localparam logic [11:0] OFS_CTRL0_ACK = 12'h024;
    localparam logic [11:0] OFS_CTRL1 = 12'h028;
    localparam logic [11:0] OFS_IRQ_CTRL = 12'h050;
    localparam logic [11:0] OFS_IRQ_ACK = 12'h054;
    localparam logic [11:0] OFS_GERR = 12'h060;
    localparam logic [11:0] OFS_GERR_ACK = 12'h064;
    localparam logic [11:0] OFS_TGT_LO = 12'h068;
    localparam logic [11:0] OFS_TGT_HI = 12'h06C;
    localparam logic [11:0] OFS_PAYLOAD = 12'h070;
    localparam logic [11:0] OFS_ATTR = 12'h074;
    localparam logic [11:0] OFS_STB_LO = 12'h080;
    localparam logic [11:0] OFS_STB_HI = 12'h084;
    localparam logic [11:0] OFS_STCFG = 12'h088;
    localparam int TGT_LSB = 2;
    localparam int STB_LSB = 6;
    localparam int RA_HI_BIT = 30;
    localparam int MT_LSB = 0;
    localparam int SH_LSB = 4;
    localparam int T_ATTR_LSB = 6;
    localparam int FMT_LSB = 16;
    localparam int SPLIT_LSB = 6;
    localparam int L2S_LSB = 0;
    localparam int CTRL_EN_BIT = 0;
    localparam logic [GERR_W-1:0] GERR_DEF_MASK = 11'h7FD;
    localparam logic [1:0] FMT_LINEAR = 2'h0;
    localparam logic [1:0] FMT_TWO_LEVEL = 2'h1;
    localparam logic [1:0] SH_NON = 2'h0;
    localparam logic [1:0] SH_RSVD = 2'h1;
    localparam logic [1:0] SH_OUTER = 2'h2;
    localparam logic [1:0] SH_INNER = 2'h3;
    localparam logic [1:0] MT_DEVICE_TOP = 2'h0;
    localparam logic [7:0] LIN_ALIGN_ADD = 8'h05;
    localparam logic [7:0] TWO_MIN_BIT = 8'h05;
    localparam logic [7:0] TWO_ADD = 8'h02;
    localparam logic [31:0] RST_WORD = 32'h0;
    localparam logic [PA_W-1:0] RST_ADDR = 56'h0;
    typedef enum logic {MSI_IDLE, MSI_BUSY} ems_msi_state_type;
endpackage

/* File: inc/ems_msi_if.sv */
// Carries one message write request from the register bank to the write issuer.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface ems_msi_if;
    logic req;
    logic busy;
    logic [55:0] addr;
    logic [31:0] data;
    logic [3:0] memtype;
    logic [1:0] share;
    modport ctrl(output req, output addr, output data, output memtype, output share,
        input busy);
    modport issuer(input req, input addr, input data, input memtype, input share,
        output busy);
endinterface

/* File: core/ems_msi_writer.sv */
// Issues the global error message write and resolves its shareability.
// Assumes the interconnect holds ready low while it cannot take the write.
`timescale 1ns/1ns
module ems_msi_writer
    import ems_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    ems_msi_if.issuer msi,
    input wire logic msi_ready_i,
    output logic msi_valid_o,
    output logic [PA_W-1:0] msi_addr_o,
    output logic [31:0] msi_data_o,
    output logic [3:0] msi_memtype_o,
    output logic [1:0] msi_share_o
);
    ems_msi_state_type state_q;

    // Device types force outer shareable; the reserved code acts as non-shareable.
    function automatic logic [1:0] eff_share(input logic [3:0] mt, input logic [1:0] sh);
        if (mt[3:2] == MT_DEVICE_TOP) begin // [RULE10]
            return SH_OUTER;
        end
        return (sh == SH_RSVD) ? SH_NON : sh; // [RULE9]
    endfunction

    assign msi.busy = (state_q == MSI_BUSY);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= MSI_IDLE;
        end else begin
            unique case (state_q)
                MSI_IDLE: if (msi.req) state_q <= MSI_BUSY;
                MSI_BUSY: if (msi_ready_i) state_q <= MSI_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            msi_valid_o <= 1'b0;
        end else if (state_q == MSI_IDLE) begin
            msi_valid_o <= msi.req;
        end else if (msi_ready_i) begin
            msi_valid_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            msi_addr_o <= RST_ADDR;
            msi_data_o <= RST_WORD;
            msi_memtype_o <= 4'h0;
            msi_share_o <= SH_NON;
        end else if (state_q == MSI_IDLE && msi.req) begin
            msi_addr_o <= {msi.addr[PA_W-1:TGT_LSB], 2'h0}; // [RULE1]
            msi_data_o <= msi.data; // [RULE22]
            msi_memtype_o <= msi.memtype;
            msi_share_o <= eff_share(msi.memtype, msi.share);
        end
    end

    chk_share_resolved: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE9]
        msi_valid_o |-> msi_share_o != SH_RSVD)
        else $error("reserved shareability issued");
    chk_device_outer: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE10]
        msi_valid_o && msi_memtype_o[3:2] == MT_DEVICE_TOP |-> msi_share_o == SH_OUTER)
        else $error("device write not outer shareable");
    chk_valid_held: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE22]
        msi_valid_o && !msi_ready_i |=> msi_valid_o && $stable(msi_data_o))
        else $error("message write dropped before ready");
endmodule

/* File: core/ems_regs.sv */
// Register bank for the global error message interrupt and the stream table base.
// Assumes a single-cycle register port master and a memory side that takes writes by ready.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
// What this block does
// [RULE1] Target address holds bits 55:2; bits 1:0 of the write address are zero.
// [RULE2] Address bits above the output address size read as zero, not stored.
// [RULE3] A zero target address sends no message; a wired interrupt may signal instead.
// [RULE4] Interrupt configuration writes are ignored while the error interrupt is enabled.
// [RULE5] Target address is writable only when enable and its acknowledge are clear.
// [RULE6] Payload and attributes are writable only when enable and acknowledge are clear.
// [RULE7] Without message support the three registers read zero and ignore writes.
// [RULE8] Payload is a full 32-bit word sent as the message data.
// [RULE9] Shareability 00 non, 10 outer, 11 inner; 01 behaves as non-shareable.
// [RULE10] A device memory type ignores shareability and writes outer shareable.
// [RULE11] Memory type bits 3:0 use the stream table entry attribute encoding.
// [RULE12] Bit 62 of the table base is the read-allocate hint for table reads.
// [RULE13] Table base holds bits 55:6; other address bits are zero.
// [RULE14] Linear format aligns the base by clearing bits up to size plus five.
// [RULE15] Two-level format clears bits up to max of five and size minus split plus two.
// [RULE16] Alignment uses the programmed size exponent, never a clamped one.
// [RULE17] Table base writes are ignored while translation is enabled.
// [RULE18] Table base is read-only when preset, else writable with enable and ack clear.
// [RULE19] Preset tables reset hint and base to chosen values, otherwise undefined.
// [RULE20] Table read cacheability and shareability come from the second control register.
// [RULE21] The error acknowledge register changes only by software writes.
// [RULE22] A new global error with enable and nonzero target sends one payload write.
module ems_regs
    import ems_pkg::*;
#(
    parameter bit MSI_SUPPORT = 1'b1,
    parameter bit TABLES_PRESET = 1'b0,
    parameter int OUTPUT_ADDRESS_SIZE = 48,
    parameter logic [PA_W-1:0] PRESET_BASE = 56'h0,
    parameter bit PRESET_RA = 1'b0,
    parameter logic [31:0] PRESET_CFG = 32'h0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic [GERR_W-1:0] gerr_event_i,
    input wire logic msi_ready_i,
    output logic msi_valid_o,
    output logic [PA_W-1:0] msi_addr_o,
    output logic [31:0] msi_data_o,
    output logic [3:0] msi_memtype_o,
    output logic [1:0] msi_share_o,
    output logic gerr_wired_irq_o,
    output logic translation_en_o,
    output logic [PA_W-1:0] strtab_base_o,
    output logic strtab_ra_o,
    output logic [ATTR_W-1:0] strtab_attr_o
);
    if (OUTPUT_ADDRESS_SIZE < 32 || OUTPUT_ADDRESS_SIZE > PA_W) begin : g_bad_oas
        $error("output address size out of range");
    end

    localparam logic [PA_W-1:0] OAS_MASK = {PA_W{1'b1}} >> (PA_W - OUTPUT_ADDRESS_SIZE);

    logic rst_s1_q;
    logic rst_n_q;
    logic ten_q;
    logic ten_ack_q;
    logic [ATTR_W-1:0] ctrl1_q;
    logic irq_en_q;
    logic irq_ack_q;
    logic [GERR_W-1:0] gerr_q;
    logic [GERR_W-1:0] gerr_ack_q;
    logic [PA_W-1:0] tgt_q;
    logic [31:0] payload_q;
    logic [5:0] attr_q;
    logic [PA_W-1:0] stb_q;
    logic ra_q;
    logic [1:0] fmt_q;
    logic [4:0] split_q;
    logic [5:0] l2s_q;
    logic pend_q;
    logic irq_open;
    logic stb_open;
    logic [GERR_W-1:0] new_act;
    logic [31:0] rd_mux;

    ems_msi_if msi_bus();

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    function automatic logic wr_hit(input logic [11:0] a, input logic w, input logic [11:0] ofs);
        return w && (a == ofs);
    endfunction

    // Kept-bit mask of the effective table base for the programmed format and size.
    function automatic logic [PA_W-1:0] align_keep(input logic [1:0] fmt,
        input logic [5:0] l2s, input logic [4:0] split);
        logic [7:0] top;
        logic [PA_W-1:0] keep;
        top = 8'({2'h0, l2s}) + LIN_ALIGN_ADD; // [RULE14] [RULE16]
        keep = '0;
        if (fmt == FMT_TWO_LEVEL) begin // [RULE15]
            if ({2'h0, l2s} > 8'({3'h0, split}) + 8'h03) begin
                top = 8'({2'h0, l2s}) - 8'({3'h0, split}) + TWO_ADD;
            end else begin
                top = TWO_MIN_BIT;
            end
        end
        for (int i = 0; i < PA_W; i++) begin
            keep[i] = (8'(i) > top);
        end
        return keep;
    endfunction

    assign irq_open = MSI_SUPPORT && !irq_en_q && !irq_ack_q; // [RULE4] [RULE5] [RULE6] [RULE7]
    assign stb_open = !TABLES_PRESET && !ten_q && !ten_ack_q; // [RULE17] [RULE18]
    assign new_act = gerr_event_i & GERR_DEF_MASK & ~(gerr_q ^ gerr_ack_q);

    // Enables and their acknowledges; an acknowledge follows its enable one cycle later.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ten_q <= 1'b0;
            ten_ack_q <= 1'b0;
            irq_en_q <= 1'b0;
            irq_ack_q <= 1'b0;
            ctrl1_q <= '0;
        end else begin
            ten_ack_q <= ten_q;
            irq_ack_q <= irq_en_q;
            if (wr_hit(reg_addr_i, reg_wr_i, OFS_CTRL0)) ten_q <= reg_wdata_i[CTRL_EN_BIT];
            if (wr_hit(reg_addr_i, reg_wr_i, OFS_IRQ_CTRL)) irq_en_q <= reg_wdata_i[CTRL_EN_BIT];
            if (wr_hit(reg_addr_i, reg_wr_i, OFS_CTRL1)) begin
                ctrl1_q <= reg_wdata_i[T_ATTR_LSB +: ATTR_W];
            end
        end
    end

    // Error status toggles only for errors not already active.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            gerr_q <= '0;
            gerr_ack_q <= '0;
        end else begin
            gerr_q <= gerr_q ^ new_act;
            if (wr_hit(reg_addr_i, reg_wr_i, OFS_GERR_ACK)) begin // [RULE21]
                gerr_ack_q <= reg_wdata_i[GERR_W-1:0] & GERR_DEF_MASK;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tgt_q <= RST_ADDR;
            payload_q <= RST_WORD;
            attr_q <= '0;
        end else if (irq_open) begin
            if (wr_hit(reg_addr_i, reg_wr_i, OFS_TGT_LO)) begin // [RULE1] [RULE2]
                tgt_q[31:0] <= {reg_wdata_i[31:TGT_LSB], 2'h0} & OAS_MASK[31:0];
            end
            if (wr_hit(reg_addr_i, reg_wr_i, OFS_TGT_HI)) begin
                tgt_q[PA_W-1:32] <= reg_wdata_i[PA_W-33:0] & OAS_MASK[PA_W-1:32];
            end
            if (wr_hit(reg_addr_i, reg_wr_i, OFS_PAYLOAD)) payload_q <= reg_wdata_i; // [RULE8]
            if (wr_hit(reg_addr_i, reg_wr_i, OFS_ATTR)) attr_q <= reg_wdata_i[5:0]; // [RULE11]
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            stb_q <= TABLES_PRESET ? (PRESET_BASE & OAS_MASK & ~56'h3F) : RST_ADDR; // [RULE19]
            ra_q <= TABLES_PRESET ? PRESET_RA : 1'b0;
            fmt_q <= TABLES_PRESET ? PRESET_CFG[FMT_LSB +: 2] : FMT_LINEAR;
            split_q <= TABLES_PRESET ? PRESET_CFG[SPLIT_LSB +: 5] : 5'h0;
            l2s_q <= TABLES_PRESET ? PRESET_CFG[L2S_LSB +: 6] : 6'h0;
        end else if (stb_open) begin
            if (wr_hit(reg_addr_i, reg_wr_i, OFS_STB_LO)) begin // [RULE13]
                stb_q[31:0] <= {reg_wdata_i[31:STB_LSB], 6'h0};
            end
            if (wr_hit(reg_addr_i, reg_wr_i, OFS_STB_HI)) begin // [RULE2] [RULE12]
                stb_q[PA_W-1:32] <= reg_wdata_i[PA_W-33:0] & OAS_MASK[PA_W-1:32];
                ra_q <= reg_wdata_i[RA_HI_BIT];
            end
            if (wr_hit(reg_addr_i, reg_wr_i, OFS_STCFG)) begin
                fmt_q <= reg_wdata_i[FMT_LSB +: 2];
                split_q <= reg_wdata_i[SPLIT_LSB +: 5];
                l2s_q <= reg_wdata_i[L2S_LSB +: 6];
            end
        end
    end

    // Pending message; a new activation wins over the hand-off to the issuer.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pend_q <= 1'b0;
        end else if (MSI_SUPPORT && irq_en_q && (tgt_q != RST_ADDR) && (|new_act)) begin
            pend_q <= 1'b1; // [RULE3] [RULE22]
        end else if (!msi_bus.busy) begin
            pend_q <= 1'b0;
        end
    end

    assign msi_bus.req = pend_q && !msi_bus.busy;
    assign msi_bus.addr = tgt_q;
    assign msi_bus.data = payload_q;
    assign msi_bus.memtype = attr_q[MT_LSB +: 4];
    assign msi_bus.share = attr_q[SH_LSB +: 2];

    ems_msi_writer u_ems_msi_writer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_q),
        .msi(msi_bus),
        .msi_ready_i(msi_ready_i),
        .msi_valid_o(msi_valid_o),
        .msi_addr_o(msi_addr_o),
        .msi_data_o(msi_data_o),
        .msi_memtype_o(msi_memtype_o),
        .msi_share_o(msi_share_o)
    );

    always_comb begin
        rd_mux = RST_WORD;
        unique case (reg_addr_i)
            OFS_CTRL0: rd_mux = {31'h0, ten_q};
            OFS_CTRL0_ACK: rd_mux = {31'h0, ten_ack_q};
            OFS_CTRL1: rd_mux = {20'h0, ctrl1_q, 6'h0};
            OFS_IRQ_CTRL: rd_mux = {31'h0, irq_en_q};
            OFS_IRQ_ACK: rd_mux = {31'h0, irq_ack_q};
            OFS_GERR: rd_mux = {21'h0, gerr_q};
            OFS_GERR_ACK: rd_mux = {21'h0, gerr_ack_q};
            OFS_TGT_LO: rd_mux = MSI_SUPPORT ? tgt_q[31:0] : RST_WORD; // [RULE7]
            OFS_TGT_HI: rd_mux = MSI_SUPPORT ? {8'h0, tgt_q[PA_W-1:32]} : RST_WORD;
            OFS_PAYLOAD: rd_mux = MSI_SUPPORT ? payload_q : RST_WORD;
            OFS_ATTR: rd_mux = MSI_SUPPORT ? {26'h0, attr_q} : RST_WORD;
            OFS_STB_LO: rd_mux = stb_q[31:0];
            OFS_STB_HI: rd_mux = {1'b0, ra_q, 6'h0, stb_q[PA_W-1:32]};
            OFS_STCFG: rd_mux = {14'h0, fmt_q, 5'h0, split_q, l2s_q};
            default: rd_mux = RST_WORD;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reg_rdata_o <= RST_WORD;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : RST_WORD;
        end
    end

    // Table read attributes and the aligned effective base for the walker.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            strtab_base_o <= RST_ADDR;
            strtab_ra_o <= 1'b0;
            strtab_attr_o <= '0;
            translation_en_o <= 1'b0;
            gerr_wired_irq_o <= 1'b0;
        end else begin
            strtab_base_o <= stb_q & align_keep(fmt_q, l2s_q, split_q); // [RULE14] [RULE15]
            strtab_ra_o <= ra_q; // [RULE12]
            strtab_attr_o <= ctrl1_q; // [RULE20]
            translation_en_o <= ten_q;
            gerr_wired_irq_o <= irq_en_q && (!MSI_SUPPORT || tgt_q == RST_ADDR)
                && (|(gerr_q ^ gerr_ack_q)); // [RULE3]
        end
    end

    chk_tgt_oas_zero: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE2]
        (tgt_q & ~OAS_MASK) == RST_ADDR && tgt_q[1:0] == 2'h0)
        else $error("target holds bits beyond address size");
    chk_zero_tgt_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE3]
        $rose(pend_q) |-> $past(tgt_q) != RST_ADDR && $past(irq_en_q))
        else $error("message pending with zero target or disabled");
    chk_guard_tgt: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE5]
        (reg_wr_i && (irq_en_q || irq_ack_q)) |=> $stable(tgt_q))
        else $error("target changed while guarded");
    chk_guard_cfg: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE6]
        (reg_wr_i && !irq_open) |=> $stable(payload_q) && $stable(attr_q))
        else $error("payload or attributes changed while guarded");
    chk_payload_read: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE7]
        reg_rd_i && reg_addr_i == OFS_PAYLOAD
        |=> reg_rdata_o == (MSI_SUPPORT ? $past(payload_q) : RST_WORD))
        else $error("payload read value wrong");
    chk_base_align: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE13]
        strtab_base_o[5:0] == 6'h0 && (strtab_base_o & ~$past(stb_q)) == RST_ADDR)
        else $error("effective base not aligned");
    chk_stb_guard: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE18]
        (reg_wr_i && !stb_open) |=> $stable(stb_q) && $stable(ra_q))
        else $error("table base changed while guarded");
    chk_ack_kept: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE21]
        !wr_hit(reg_addr_i, reg_wr_i, OFS_GERR_ACK) |=> $stable(gerr_ack_q))
        else $error("acknowledge changed without a write");
    chk_msi_issue: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE22]
        msi_bus.req |=> msi_valid_o && msi_data_o == $past(payload_q))
        else $error("pending message not issued");

    // Registered copies and read paths follow their sources by one cycle.
    chk_irq_ack_lag: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE5]
        1'b1 |=> irq_ack_q == $past(irq_en_q))
        else $error("interrupt acknowledge not lagging enable");
    chk_ten_ack_lag: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE18]
        1'b1 |=> ten_ack_q == $past(ten_q))
        else $error("translation acknowledge not lagging enable");
    chk_ten_follow: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE17]
        1'b1 |=> translation_en_o == $past(ten_q))
        else $error("translation enable output wrong");
    chk_msi_target: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE1]
        $rose(msi_valid_o) |-> msi_addr_o == $past(tgt_q))
        else $error("message address differs from target");
    chk_stb_zero: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE2] [RULE13]
        (stb_q & ~OAS_MASK) == RST_ADDR && stb_q[5:0] == 6'h0)
        else $error("table base holds cleared bits");
    chk_ra_follow: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE12]
        1'b1 |=> strtab_ra_o == $past(ra_q))
        else $error("read-allocate output wrong");
    chk_attr_follow: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE20]
        1'b1 |=> strtab_attr_o == $past(ctrl1_q))
        else $error("table attribute output wrong");
    chk_wired_gate: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE3]
        gerr_wired_irq_o |-> $past(irq_en_q) && (!MSI_SUPPORT || $past(tgt_q) == RST_ADDR))
        else $error("wired interrupt with a message target");
    chk_tgt_read: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE7]
        reg_rd_i && reg_addr_i == OFS_TGT_LO
        |=> reg_rdata_o == (MSI_SUPPORT ? $past(tgt_q[31:0]) : RST_WORD))
        else $error("target read value wrong");
    chk_ack_read: assert property (@(posedge clk_i) disable iff (!rst_n_q) // [RULE21]
        reg_rd_i && reg_addr_i == OFS_GERR_ACK |=> reg_rdata_o == {21'h0, $past(gerr_ack_q)})
        else $error("acknowledge read value wrong");

    cov_msi_sent: cover property (@(posedge clk_i) disable iff (!rst_n_q)
        msi_valid_o && msi_ready_i);
    cov_two_level: cover property (@(posedge clk_i) disable iff (!rst_n_q)
        fmt_q == FMT_TWO_LEVEL && stb_q != RST_ADDR);
    cov_guarded_wr: cover property (@(posedge clk_i) disable iff (!rst_n_q)
        wr_hit(reg_addr_i, reg_wr_i, OFS_PAYLOAD) && irq_en_q);
    cov_wired: cover property (@(posedge clk_i) disable iff (!rst_n_q) gerr_wired_irq_o);
    cov_stb_guarded: cover property (@(posedge clk_i) disable iff (!rst_n_q)
        wr_hit(reg_addr_i, reg_wr_i, OFS_STB_LO) && ten_q);
endmodule

/* File: bench/ems_sink.sv */
// Behavioural interconnect that takes message writes, stalling at random when asked.
// Assumes valid and its fields hold until ready is seen high at a rising edge.
`timescale 1ns/1ns
module ems_sink (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic stall_i,
    input wire logic valid_i,
    input wire logic [55:0] addr_i,
    input wire logic [31:0] data_i,
    input wire logic [3:0] mt_i,
    input wire logic [1:0] sh_i,
    output logic ready_o,
    output int n_o,
    output logic [93:0] last_o
);
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_o <= 1'b0;
            n_o <= 0;
        end else begin
            if (valid_i && ready_o) begin
                n_o <= n_o + 1;
                last_o <= {addr_i, data_i, mt_i, sh_i};
            end
            ready_o <= stall_i ? 1'($urandom) : 1'b1;
        end
    end
endmodule

/* File: bench/tb_error_msi_and_stream_table_cfg.sv */
// Self-checking bench for the error message and stream table register bank.
// Assumes the bank's default parameters and a sink that may stall.
`timescale 1ns/1ns
module tb_error_msi_and_stream_table_cfg
    import ems_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [GERR_W-1:0] gerr_event_i = '0;
    logic stall = 1'b0;
    logic [31:0] reg_rdata_o, msi_data_o, pay;
    logic msi_ready_i, msi_valid_o, gerr_wired_irq_o, translation_en_o, strtab_ra_o;
    logic [PA_W-1:0] msi_addr_o, strtab_base_o, tgt, base, m;
    logic [3:0] msi_memtype_o, mt;
    logic [1:0] msi_share_o, sh, esh;
    logic [ATTR_W-1:0] strtab_attr_o;
    logic [93:0] last, got_msg;
    logic [93:0] exp_q[$];
    int n_msi, top, sz, split;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;

    ems_regs u_ems_regs (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .gerr_event_i(gerr_event_i), .msi_ready_i(msi_ready_i),
        .msi_valid_o(msi_valid_o), .msi_addr_o(msi_addr_o), .msi_data_o(msi_data_o),
        .msi_memtype_o(msi_memtype_o), .msi_share_o(msi_share_o),
        .gerr_wired_irq_o(gerr_wired_irq_o), .translation_en_o(translation_en_o),
        .strtab_base_o(strtab_base_o), .strtab_ra_o(strtab_ra_o),
        .strtab_attr_o(strtab_attr_o));
    ems_sink u_ems_sink (.clk_i(clk_i), .rst_n_i(rst_n_i), .stall_i(stall),
        .valid_i(msi_valid_o), .addr_i(msi_addr_o), .data_i(msi_data_o),
        .mt_i(msi_memtype_o), .sh_i(msi_share_o), .ready_o(msi_ready_i), .n_o(n_msi),
        .last_o(last));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Every accepted message write is matched against the model's next expected one.
    always @(negedge clk_i) begin
        if (msi_valid_o && msi_ready_i) begin
            chk(exp_q.size(), 1);
            if (exp_q.size() > 0) begin
                got_msg = {msi_addr_o, msi_data_o, msi_memtype_o, msi_share_o};
                chk(got_msg, exp_q.pop_front());
            end
        end
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rdata_o, exp);
    endtask

    task automatic ev(input int b);
        @(posedge clk_i);
        gerr_event_i <= GERR_W'(1) << b;
        @(posedge clk_i);
        gerr_event_i <= '0;
    endtask

    initial begin
        void'($urandom(32'h4006));
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        tgt = {8'h0, 16'($urandom), 30'($urandom), 2'h0} | 56'h4;
        pay = $urandom;
        wr(OFS_TGT_LO, tgt[31:0] | 32'h3);
        wr(OFS_TGT_HI, {16'hFFFF, tgt[47:32]});
        wr(OFS_PAYLOAD, pay);
        rd(OFS_TGT_LO, tgt[31:0]);
        rd(OFS_TGT_HI, {16'h0, tgt[47:32]});
        rd(OFS_PAYLOAD, pay);
        rd(12'h0FC, 32'h0);
        $display("register readback test done");
        stall <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            mt = i[0] ? 4'hF : 4'h1;
            sh = 2'(i >> 1);
            esh = (mt[3:2] == 2'h0) ? 2'h2 : ((sh == 2'h1) ? 2'h0 : sh);
            wr(OFS_IRQ_CTRL, 32'h0);
            repeat (3) @(posedge clk_i);
            wr(OFS_ATTR, {26'h0, sh, mt});
            wr(OFS_IRQ_CTRL, 32'h1);
            exp_q.push_back({tgt, pay, mt, esh});
            ev(i + 2);
            for (int k = 0; k < 60 && n_msi < i + 1; k++) @(posedge clk_i);
            chk(last, {tgt, pay, mt, esh});
        end
        wr(OFS_PAYLOAD, ~pay);
        wr(OFS_TGT_LO, 32'h0);
        rd(OFS_PAYLOAD, pay);
        rd(OFS_TGT_LO, tgt[31:0]);
        $display("message write test done");
        wr(OFS_IRQ_CTRL, 32'h0);
        repeat (3) @(posedge clk_i);
        wr(OFS_TGT_LO, 32'h0);
        wr(OFS_TGT_HI, 32'h0);
        wr(OFS_IRQ_CTRL, 32'h1);
        ev(10);
        repeat (30) @(posedge clk_i);
        chk(n_msi, 8);
        chk(gerr_wired_irq_o, 1'b1);
        rd(OFS_GERR, 32'h7FC);
        wr(OFS_GERR_ACK, 32'h7);
        rd(OFS_GERR_ACK, 32'h5);
        $display("zero target test done");
        wr(OFS_CTRL1, 32'hFC0);
        for (int i = 0; i < 6; i++) begin
            base = {8'h0, 16'($urandom), 32'($urandom)};
            sz = $urandom_range(20);
            split = 6 + 2 * (i % 3);
            wr(OFS_STCFG, {14'h0, 1'(i == 4), i[0], 5'h0, 5'(split), 6'(sz)});
            wr(OFS_STB_LO, base[31:0]);
            wr(OFS_STB_HI, {1'b1, i[0], 6'h3F, 8'hFF, base[47:32]});
            top = i[0] ? ((sz - split + 2 > 5) ? sz - split + 2 : 5) : sz + 5;
            m = ~((56'h2 << top) - 56'h1);
            @(posedge clk_i);
            #1;
            chk(strtab_base_o, base & m);
            chk(strtab_ra_o, i[0]);
        end
        chk(strtab_attr_o, 6'h3F);
        wr(OFS_CTRL0, 32'h1);
        wr(OFS_STB_LO, 32'h0);
        rd(OFS_STB_LO, base[31:0] & 32'hFFFFFFC0);
        chk(translation_en_o, 1'b1);
        $display("stream table test done");
        wrap_up();
    end
endmodule
